// [hw/cbsf_state.sv]
// Socket present state and force event register logic
//
// Summary of operation
// RQ1: Socket Y and X supply capability bits read zero unless forced.
// RQ2: Socket 3.3 V capability bit reads one unless forced otherwise.
// RQ3: Socket 5 V capability reads one unless control bit 6 clears it.
// RQ4: State bits 27 to 14 read zero.
// RQ5: Card Y, X, 3.3 V support bits, each settable via force register.
// RQ6: Card 5 V support reported in its own bit.
// RQ7: Invalid supply request sets a flag; default zero.
// RQ8: Removal with possible data loss sets a flag; default zero.
// RQ9: Unrecognized card flag holds until a valid card is inserted.
// RQ10: Ready/interrupt pin level shown live in bit 6.
// RQ11: Card type bits update only at a new interrogation.
// RQ12: Power state bit: zero powered down, one powered up.
// RQ13: Card-detect pins mirrored, frozen during interrogation.
// RQ14: Status-change pin level shown live in bit 0.
// RQ15: Force register writes alter event and state; 31-15, 6 read-only.
// RQ16: Software writes retest when forcing a change needing interrogation.
// RQ17: Forced power, detect and status-change write events only.
// RQ18: Retest reinterrogates, refreshes state, re-enables power control.
// RQ19: Forced card-voltage bits write state and disable power control.
// RQ20: Software writes to the state register are ignored.
`timescale 1ns/1ps
`default_nettype none
module cbsf_state
    import cbsf_pkg::*;
#(
    parameter int INTERROG_CYC = CBSF_INTERROG_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Card pins
    input  wire logic        card_detect_pin_one,
    input  wire logic        card_detect_pin_two,
    input  wire logic        card_status_change_pin,
    input  wire logic        card_ready_irq_pin,
    // Card identification results
    input  wire logic [3:0]  card_volt_sense,
    input  wire logic        card_is_cardbus,
    input  wire logic        card_is_16bit,
    input  wire logic        card_unrecognized,
    // Power and error events from the rest of the bridge
    input  wire logic        supply_req_invalid,
    input  wire logic        removal_data_risk,
    input  wire logic        socket_powered,
    // Power control and interrogation status
    output logic             power_ctrl_en,
    output logic             interrog_busy
);
    typedef enum logic [1:0] {CBSF_IDLE, CBSF_PROBE} cbsf_st_t;

    logic [3:0]  pin_s;
    logic        cd1_s, cd2_s, sts_s, irq_s;
    logic        wr_force, wr_event, wr_ctrl;
    logic [31:0] state_word;
    cbsf_st_t    st_r;
    logic [15:0] cnt_r;
    logic        present_prev_r;
    logic        present_now;
    logic        start_probe;
    logic        probe_done;

    // Live state fields
    logic        sock_y_r, sock_x_r, sock_low_r;
    logic        high_ovr_r;
    logic [3:0]  card_volt_r;
    logic        badreq_r, lost_r, notcard_r;
    logic        cardbus_card_found_r, card16_r, pwr_r;
    logic        cd1_r, cd2_r;
    // Event bits
    logic [3:0]  event_r;
    logic        pwr_prev_r, cd1_prev_r, cd2_prev_r, sts_prev_r;

    // Pins are asynchronous to sys_clk; detects idle high, levels idle low
    // so the change detectors see no false edge after reset
    cbsf_sync #(.W(4), .RST_VAL(4'h3)) cbsf_sync_inst (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .d       ({card_ready_irq_pin, card_status_change_pin,
                   card_detect_pin_two, card_detect_pin_one}),
        .q       (pin_s)
    );
    assign cd1_s = pin_s[0];
    assign cd2_s = pin_s[1];
    assign sts_s = pin_s[2];
    assign irq_s = pin_s[3];

    // Write decode; writes to the state offset decode to nothing
    assign wr_force = reg_wr && (reg_addr == CBSF_OFF_FORCE); // [RQ15] [RQ20]
    assign wr_event = reg_wr && (reg_addr == CBSF_OFF_EVENT);
    assign wr_ctrl  = reg_wr && (reg_addr == CBSF_OFF_CTRL);

    // Insertion: both detect pins go low
    assign present_now = !cd1_s && !cd2_s;
    assign start_probe = (present_now && !present_prev_r) ||
                         (wr_force && reg_wdata[CBSF_B_RETEST]); // [RQ18]
    assign probe_done  = (st_r == CBSF_PROBE) &&
                         (cnt_r == 16'(INTERROG_CYC - 1));

    // Interrogation sequencer
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_r           <= CBSF_IDLE;
            cnt_r          <= 16'h0000;
            present_prev_r <= 1'b0;
            interrog_busy  <= 1'b0;
        end else begin
            present_prev_r <= present_now;
            case (st_r)
                CBSF_IDLE: begin
                    cnt_r <= 16'h0000;
                    if (start_probe) begin
                        st_r          <= CBSF_PROBE;
                        interrog_busy <= 1'b1;
                    end
                end
                CBSF_PROBE: begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (probe_done) begin
                        st_r          <= CBSF_IDLE;
                        interrog_busy <= 1'b0;
                    end
                end
                default: begin
                    st_r          <= CBSF_IDLE;
                    interrog_busy <= 1'b0;
                end
            endcase
        end
    end

    // Socket capability bits; only a force write changes them
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sock_y_r   <= CBSF_SOCK_CAP_RST[3]; // [RQ1]
            sock_x_r   <= CBSF_SOCK_CAP_RST[2]; // [RQ1]
            sock_low_r <= CBSF_SOCK_CAP_RST[1]; // [RQ2]
        end else if (wr_force) begin
            // Force bits 13..11 alias onto the socket bits as well
            sock_y_r   <= reg_wdata[CBSF_B_CARD_Y];   // [RQ1]
            sock_x_r   <= reg_wdata[CBSF_B_CARD_X];   // [RQ1]
            sock_low_r <= reg_wdata[CBSF_B_CARD_LOW]; // [RQ2]
        end
    end

    // High supply override lives in the control register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            high_ovr_r <= 1'b0;
        end else if (wr_ctrl) begin
            high_ovr_r <= reg_wdata[CBSF_B_HIGH_OVR]; // [RQ3]
        end
    end

    // Card supply support and card type, updated per interrogation
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            card_volt_r <= 4'h0;
            cardbus_card_found_r    <= 1'b0;
            card16_r    <= 1'b0;
            notcard_r   <= 1'b0;
        end else if (wr_force) begin
            // Force writes win over a concurrent probe end
            card_volt_r <= reg_wdata[CBSF_B_CARD_Y:CBSF_B_CARD_HIGH]; // [RQ5]
            cardbus_card_found_r    <= reg_wdata[CBSF_B_CARDBUS_CARD_FOUND];  // [RQ15]
            card16_r    <= reg_wdata[CBSF_B_16CARD];  // [RQ15]
            notcard_r   <= reg_wdata[CBSF_B_NOTCARD]; // [RQ15]
        end else if (probe_done) begin
            card_volt_r <= card_volt_sense;   // [RQ5] [RQ6] [RQ18]
            cardbus_card_found_r    <= card_is_cardbus;   // [RQ11]
            card16_r    <= card_is_16bit;     // [RQ11]
            // Cleared only by a valid card
            if (card_unrecognized)
                notcard_r <= 1'b1;            // [RQ9]
            else if (card_is_cardbus || card_is_16bit)
                notcard_r <= 1'b0;            // [RQ9]
        end
    end

    // Sticky error flags; hardware set beats software force
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            badreq_r <= 1'b0;
            lost_r   <= 1'b0;
        end else begin
            if (supply_req_invalid)
                badreq_r <= 1'b1;                        // [RQ7]
            else if (wr_force)
                badreq_r <= reg_wdata[CBSF_B_BADREQ];
            if (removal_data_risk)
                lost_r <= 1'b1;                          // [RQ8]
            else if (wr_force)
                lost_r <= reg_wdata[CBSF_B_LOST];
        end
    end

    // Power state and detect mirrors; detect frozen while probing
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pwr_r <= 1'b0;
            cd1_r <= 1'b1;
            cd2_r <= 1'b1;
        end else begin
            pwr_r <= socket_powered;          // [RQ12]
            if (st_r != CBSF_PROBE) begin
                cd1_r <= cd1_s;               // [RQ13]
                cd2_r <= cd2_s;               // [RQ13]
            end
        end
    end

    // Power control enable: forced voltage disables, retest restores
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            power_ctrl_en <= 1'b1;
        end else if (wr_force && reg_wdata[CBSF_B_RETEST]) begin
            power_ctrl_en <= 1'b1;            // [RQ18]
        end else if (wr_force &&
                     |reg_wdata[CBSF_B_CARD_Y:CBSF_B_CARD_HIGH]) begin
            power_ctrl_en <= 1'b0;            // [RQ19]
        end
    end

    // Event bits: change detect or force write sets; write-one clears
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            event_r    <= 4'h0;
            pwr_prev_r <= 1'b0;
            cd1_prev_r <= 1'b1;
            cd2_prev_r <= 1'b1;
            sts_prev_r <= 1'b0;
        end else begin
            pwr_prev_r <= pwr_r;
            cd1_prev_r <= cd1_r;
            cd2_prev_r <= cd2_r;
            sts_prev_r <= sts_s;
            // Set beats clear in the same cycle
            event_r <= (event_r & ~(wr_event ? reg_wdata[3:0] : 4'h0))
                     | {pwr_r ^ pwr_prev_r, cd2_r ^ cd2_prev_r,
                        cd1_r ^ cd1_prev_r, sts_s ^ sts_prev_r}
                     | (wr_force ? reg_wdata[3:0] : 4'h0); // [RQ17]
        end
    end

    // Assemble the state word
    always_comb begin
        state_word = 32'h0000_0000;                    // [RQ4]
        state_word[CBSF_B_SOCK_Y]    = sock_y_r;        // [RQ1]
        state_word[CBSF_B_SOCK_X]    = sock_x_r;        // [RQ1]
        state_word[CBSF_B_SOCK_LOW]  = sock_low_r;      // [RQ2]
        state_word[CBSF_B_SOCK_HIGH] = !high_ovr_r;     // [RQ3]
        state_word[CBSF_B_CARD_Y:CBSF_B_CARD_HIGH] = card_volt_r;
        state_word[CBSF_B_BADREQ]    = badreq_r;
        state_word[CBSF_B_LOST]      = lost_r;
        state_word[CBSF_B_NOTCARD]   = notcard_r;
        state_word[CBSF_B_IRQ]       = irq_s;           // [RQ10]
        state_word[CBSF_B_CARDBUS_CARD_FOUND]    = cardbus_card_found_r;
        state_word[CBSF_B_16CARD]    = card16_r;
        state_word[CBSF_B_PWR]       = pwr_r;
        state_word[CBSF_B_CD2]       = cd2_r;
        state_word[CBSF_B_CD1]       = cd1_r;
        state_word[CBSF_B_STS]       = sts_s;           // [RQ14]
    end

    // Read data one cycle after the strobe; force reads zero
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                CBSF_OFF_EVENT: reg_rdata <= {28'h0000000, event_r};
                CBSF_OFF_STATE: reg_rdata <= state_word;
                CBSF_OFF_CTRL:  reg_rdata <= 32'(high_ovr_r) << CBSF_B_HIGH_OVR;
                default:        reg_rdata <= 32'h0000_0000; // [RQ15]
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule // cbsf_state
`default_nettype wire

// [inc/cbsf_pkg.sv]
// Package of offsets, field positions and timing for the socket state block
package cbsf_pkg;
    // Register word offsets (byte addresses)
    localparam logic [7:0] CBSF_OFF_EVENT   = 8'h00;
    localparam logic [7:0] CBSF_OFF_STATE   = 8'h08;
    localparam logic [7:0] CBSF_OFF_FORCE   = 8'h0C;
    localparam logic [7:0] CBSF_OFF_CTRL    = 8'h14;
    // State register field positions
    localparam int CBSF_B_SOCK_Y    = 31;
    localparam int CBSF_B_SOCK_X    = 30;
    localparam int CBSF_B_SOCK_LOW  = 29;
    localparam int CBSF_B_SOCK_HIGH = 28;
    localparam int CBSF_B_CARD_Y    = 13;
    localparam int CBSF_B_CARD_X    = 12;
    localparam int CBSF_B_CARD_LOW  = 11;
    localparam int CBSF_B_CARD_HIGH = 10;
    localparam int CBSF_B_BADREQ    = 9;
    localparam int CBSF_B_LOST      = 8;
    localparam int CBSF_B_NOTCARD   = 7;
    localparam int CBSF_B_IRQ       = 6;
    localparam int CBSF_B_CARDBUS_CARD_FOUND    = 5;
    localparam int CBSF_B_16CARD    = 4;
    localparam int CBSF_B_PWR       = 3;
    localparam int CBSF_B_CD2       = 2;
    localparam int CBSF_B_CD1       = 1;
    localparam int CBSF_B_STS       = 0;
    // Force register extra fields
    localparam int CBSF_B_RETEST    = 14;
    // Control register: high-supply override bit
    localparam int CBSF_B_HIGH_OVR  = 6;
    // Writable mask of the force register
    localparam logic [31:0] CBSF_FORCE_WMASK = 32'h0000_7FBF;
    // Reset value of the capability bits of the socket
    localparam logic [3:0] CBSF_SOCK_CAP_RST = 4'h3;
    // Interrogation duration
    localparam int CBSF_INTERROG_NS = 1000;
    localparam int CBSF_CLK_NS      = 10;
    localparam int CBSF_INTERROG_CYC =
        (CBSF_INTERROG_NS + CBSF_CLK_NS - 1) / CBSF_CLK_NS;
endpackage

// [hw/cbsf_sync.sv]
// Two-stage synchroniser for the card pins
`timescale 1ns/1ps
`default_nettype none
module cbsf_sync #(
    parameter int           W       = 4,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second; reset to each pin's idle level
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // cbsf_sync
`default_nettype wire

// [sim/cbsf_state_sva.sv]
// Port checker for the socket state block
`timescale 1ns/1ps
`default_nettype none
module cbsf_state_chk
    import cbsf_pkg::*;
#(
    parameter int INTERROG_CYC = CBSF_INTERROG_CYC
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        resetn,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Pins and status
    input wire logic        card_status_change_pin,
    input wire logic        card_ready_irq_pin,
    input wire logic        power_ctrl_en,
    input wire logic        interrog_busy
);
    logic [15:0] busy_cnt_r;
    logic [4:0]  irq_hist_r;
    logic [4:0]  sts_hist_r;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Busy length, saturating so it cannot wrap under the limit
    always_ff @(posedge sys_clk) begin
        if (!resetn || !interrog_busy) busy_cnt_r <= 16'h0000;
        else if (busy_cnt_r != 16'hFFFF) busy_cnt_r <= busy_cnt_r + 16'h0001;
    end
    // Pin history; mixed reset value so a live check needs real samples
    always_ff @(posedge sys_clk) begin
        if (!resetn) irq_hist_r <= 5'h0A;
        else irq_hist_r <= {irq_hist_r[3:0], card_ready_irq_pin};
        if (!resetn) sts_hist_r <= 5'h0A;
        else sts_hist_r <= {sts_hist_r[3:0], card_status_change_pin};
    end
    a_state_rsvd_zero: assert property ($past(reg_rd) &&
        $past(reg_addr) == CBSF_OFF_STATE |-> reg_rdata[27:14] == 14'h0000)
        else $error("state reserved bits not zero");
    a_force_reads_zero: assert property ($past(reg_rd) &&
        $past(reg_addr) == CBSF_OFF_FORCE |-> reg_rdata == 32'h0000_0000)
        else $error("force register read not zero");
    a_probe_len_bound: assert property (interrog_busy |->
        int'(busy_cnt_r) < INTERROG_CYC)
        else $error("interrogation runs too long");
    a_retest_starts_probe: assert property (reg_wr &&
        reg_addr == CBSF_OFF_FORCE && reg_wdata[CBSF_B_RETEST]
        |-> ##[1:3] interrog_busy) else $error("retest did not probe");
    a_force_power_off: assert property (reg_wr &&
        reg_addr == CBSF_OFF_FORCE && |reg_wdata[13:10] &&
        !reg_wdata[CBSF_B_RETEST] |=> !power_ctrl_en)
        else $error("forced voltage left power control on");
    a_retest_power_on: assert property (reg_wr &&
        reg_addr == CBSF_OFF_FORCE && reg_wdata[CBSF_B_RETEST]
        |-> ##[1:2] power_ctrl_en) else $error("retest left power off");
    a_irq_level_live: assert property ($past(reg_rd) &&
        $past(reg_addr) == CBSF_OFF_STATE && (irq_hist_r == 5'h00 ||
        irq_hist_r == 5'h1F) |-> reg_rdata[CBSF_B_IRQ] == irq_hist_r[0])
        else $error("ready level not mirrored");
    a_sts_level_live: assert property ($past(reg_rd) &&
        $past(reg_addr) == CBSF_OFF_STATE && (sts_hist_r == 5'h00 ||
        sts_hist_r == 5'h1F) |-> reg_rdata[CBSF_B_STS] == sts_hist_r[0])
        else $error("status level not mirrored");
    c_force_write: cover property (reg_wr && reg_addr == CBSF_OFF_FORCE);
    c_probe_done: cover property ($fell(interrog_busy));
    c_power_off: cover property ($fell(power_ctrl_en));
endmodule // cbsf_state_chk
bind cbsf_state cbsf_state_chk #(.INTERROG_CYC(INTERROG_CYC)) chk_inst (
    .sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .card_status_change_pin, .card_ready_irq_pin, .power_ctrl_en,
    .interrog_busy);
`default_nettype wire

// [sim/cbsf_card.sv]
// Behavioural model of the card standing in the socket
`timescale 1ns/1ps
`default_nettype none
module cbsf_card (
    // Scenario controls
    input  wire logic       inserted,
    input  wire logic [3:0] volts,
    input  wire logic       cardbus,
    input  wire logic       ready,
    input  wire logic       status,
    // Socket pins and identification
    output logic            cd_one_n,
    output logic            cd_two_n,
    output logic            sts_pin,
    output logic            irq_pin,
    output logic [3:0]      sense,
    output logic            is_cb,
    output logic            is_16,
    output logic            unknown
);
    // Detect pins pulled high in an empty socket
    assign cd_one_n = !inserted;
    assign cd_two_n = !inserted;
    // Level pins pulled low once the card is gone
    assign sts_pin = inserted && status;
    assign irq_pin = inserted && ready;
    // Floating sense lines show a changed pattern, not the last value
    assign sense = inserted ? volts : ~volts;
    assign is_cb = inserted && cardbus && volts != 4'h0;
    assign is_16 = inserted && !cardbus && volts != 4'h0;
    assign unknown = inserted && volts == 4'h0;
endmodule // cbsf_card
`default_nettype wire

// [sim/cbsf_state_test.sv]
// Self-checking bench for the socket state block
`timescale 1ns/1ps
`default_nettype none
module cbsf_state_test;
    import cbsf_pkg::*;
    logic sys_clk, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic ins = 1'b0, cb = 1'b0, rdy = 1'b0, sts = 1'b0, pwr = 1'b0;
    logic badreq = 1'b0, risk = 1'b0;
    logic [3:0] volts = 4'h0, sense;
    logic cd1, cd2, sp, ip, is_cb, is_16, unk, pce, busy;
    int fails = 0, checks_done = 0;
    cbsf_card cbsf_card_inst (.inserted(ins), .volts(volts), .cardbus(cb),
        .ready(rdy), .status(sts), .cd_one_n(cd1), .cd_two_n(cd2),
        .sts_pin(sp), .irq_pin(ip), .sense(sense), .is_cb(is_cb),
        .is_16(is_16), .unknown(unk));
    cbsf_state #(.INTERROG_CYC(4)) cbsf_state_inst (.sys_clk, .resetn,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .card_detect_pin_one(cd1), .card_detect_pin_two(cd2),
        .card_status_change_pin(sp), .card_ready_irq_pin(ip),
        .card_volt_sense(sense), .card_is_cardbus(is_cb),
        .card_is_16bit(is_16), .card_unrecognized(unk),
        .supply_req_invalid(badreq), .removal_data_risk(risk),
        .socket_powered(pwr), .power_ctrl_en(pce), .interrog_busy(busy));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e & m);
    endtask
    // Bounded wait for one whole interrogation, then pins settle
    task automatic wait_probe;
        for (int i = 0; i < 30 && busy !== 1'b1; i++) @(posedge sys_clk);
        chk(busy, 1'b1);
        for (int i = 0; i < 30 && busy !== 1'b0; i++) @(posedge sys_clk);
        repeat (5) @(posedge sys_clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic t_reset_and_ro;
        rd(CBSF_OFF_STATE, 32'h3000_0006, '1);
        wr(CBSF_OFF_STATE, 32'hFFFF_FFFF);
        rd(CBSF_OFF_STATE, 32'h3000_0006, '1);
        rd(8'h40, 32'h0, '1);
        rd(CBSF_OFF_FORCE, 32'h0, '1);
        rd(CBSF_OFF_EVENT, 32'h0, '1);
    endtask
    task automatic t_insert_and_live;
        volts <= 4'hA;
        cb <= 1'b1;
        ins <= 1'b1;
        wait_probe();
        rd(CBSF_OFF_STATE, 32'h3000_2820, '1);
        volts <= 4'h5;
        rdy <= 1'b1;
        sts <= 1'b1;
        pwr <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd(CBSF_OFF_STATE, 32'h3000_2869, '1);
        badreq <= 1'b1;
        risk <= 1'b1;
        @(posedge sys_clk);
        badreq <= 1'b0;
        risk <= 1'b0;
        rd(CBSF_OFF_STATE, 32'h3000_2B69, '1);
    endtask
    task automatic t_force;
        wr(CBSF_OFF_EVENT, 32'h0000_000F);
        wr(CBSF_OFF_FORCE, 32'h0000_3FBF);
        chk(pce, 1'b0);
        rd(CBSF_OFF_STATE, 32'hF000_3FF9, '1);
        rd(CBSF_OFF_EVENT, 32'h0000_000F, '1);
        wr(CBSF_OFF_CTRL, 32'h0000_0040);
        rd(CBSF_OFF_STATE, 32'h0, 32'h1000_0000);
        wr(CBSF_OFF_CTRL, 32'h0);
        rd(CBSF_OFF_STATE, 32'h1000_0000, 32'h1000_0000);
    endtask
    task automatic t_retest;
        volts <= 4'h0;
        wr(CBSF_OFF_FORCE, 32'h0000_4000);
        wait_probe();
        chk(pce, 1'b1);
        rd(CBSF_OFF_STATE, 32'h0000_00C9, 32'h3FFF);
        volts <= 4'h4;
        cb <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rd(CBSF_OFF_STATE, 32'h0000_00C9, 32'h3FFF);
        wr(CBSF_OFF_FORCE, 32'h0000_4000);
        wait_probe();
        rd(CBSF_OFF_STATE, 32'h0000_1059, 32'h3FFF);
        ins <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rd(CBSF_OFF_STATE, 32'h0000_0006, 32'h0000_0047);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        #100000;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_reset_and_ro();
        t_insert_and_live();
        t_force();
        t_retest();
        report_and_stop();
    end
endmodule // cbsf_state_test
`default_nettype wire
